// ===== rtl/adp_pkg.sv
/*
  Shared constants and register map of the accessory-port output
  and analog input block. Assumes a 32-bit Avalon-MM slave at 25 MHz.
*/
package adp_pkg;
  localparam int ADP_NOUT = 4;
  localparam int ADP_ADC_BITS = 12;
  // Byte offsets on the Avalon-MM bus.
  localparam logic [7:0] ADP_OFS_OUT = 8'h00;
  localparam logic [7:0] ADP_OFS_BIT = 8'h04;
  localparam logic [7:0] ADP_OFS_PRESET = 8'h08;
  localparam logic [7:0] ADP_OFS_PBIT = 8'h0C;
  localparam logic [7:0] ADP_OFS_CTRL = 8'h10;
  localparam logic [7:0] ADP_OFS_PIN = 8'h14;
  localparam logic [7:0] ADP_OFS_ANA_SEL = 8'h18;
  localparam logic [7:0] ADP_OFS_ANA_DATA = 8'h1C;
  // String write field: count in [10:8], characters in [3:0].
  localparam int ADP_LEN_LSB = 8;
  // Single-bit write field: index in [7:4], level in [1:0].
  localparam int ADP_IDX_LSB = 4;
  // Control register fields.
  localparam int ADP_CTRL_LED_MAN = 2;
  localparam int ADP_CTRL_SHUT_LSB = 8;
  localparam int ADP_CTRL_BRIGHT_LSB = 16;
  // Analog selector: channel in [4:0], high resolution in bit 8.
  localparam int ADP_SEL_HIRES = 8;
  localparam logic [4:0] ADP_CH_AUX = 5'h0A;
  localparam logic [4:0] ADP_CH_MOTOR = 5'h1C;
  localparam logic [3:0] ADP_PRESET_RST = 4'h0;
  localparam logic [31:0] ADP_UNMAPPED = 32'h0000_0000;
  localparam int ADP_ANA_WAIT = 2;
endpackage : adp_pkg

// ===== rtl/adp_ana_if.sv
/*
  Carrier between the top and its analog sampler. Assumes one clock.
*/
`timescale 1ns/1ps
interface adp_ana_if;
  logic req;
  logic [4:0] chan;
  logic hires;
  logic ack;
  logic [31:0] value;
  modport top (output req, output chan, output hires,
               input ack, input value);
  modport smp (input req, input chan, input hires,
               output ack, output value);
endinterface : adp_ana_if

// ===== rtl/adp_ana_sample.sv
/*
  Analog read sampler: picks a channel, scales it and answers after a
  fixed wait. Assumes converter words already synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
module adp_ana_sample
  import adp_pkg::*;
#(
  parameter int BITS = ADP_ADC_BITS
) (
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic [15:0] aux_adc_in,
  input wire logic [15:0] motor_volt_in,
  input wire logic [15:0] gen_adc_in,
  adp_ana_if.smp ana
);
  // The plain count needs ten converter bits; the fraction fits 16.
  if (BITS < 10 || BITS > 16) begin : g_bad_bits
    $error("adc width must be 10 to 16");
  end

  typedef struct packed {
    logic busy;
    logic [1:0] cnt;
    logic ack;
    logic [31:0] value;
  } adp_smp_t;

  adp_smp_t s_q, s_d;
  logic [15:0] raw;
  logic [9:0] plain;
  logic [6:0] frac;

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    case (ana.chan)
      ADP_CH_AUX: raw = aux_adc_in;
      default: raw = gen_adc_in;
    endcase
    plain = raw[BITS-1 -: 10];
    frac = 7'h00;
    if (BITS > 10) begin
      frac = 7'((32'(raw) & ((32'h1 << (BITS - 10)) - 32'h1)) * 32'd100
             >> (BITS - 10));
    end
    if (ana.req && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.cnt = 2'(ADP_ANA_WAIT);
    end else if (s_q.busy) begin
      if (s_q.cnt == 2'h0) begin
        s_d.busy = 1'b0;
        s_d.ack = 1'b1;
        if (ana.chan == ADP_CH_MOTOR) begin
          s_d.value = {16'h0000, motor_volt_in};
        end else if (ana.hires && BITS > 10) begin
          s_d.value = {15'h0000, plain, frac};
        end else begin
          s_d.value = {22'h000000, plain};
        end
      end else begin
        s_d.cnt = s_q.cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ana.ack = s_q.ack;
  assign ana.value = s_q.value;

  a_ack_after_wait: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (ana.req && !s_q.busy) |-> ##4 s_q.ack)
    else $error("analog answer late");
  cv_motor: cover property (@(posedge clk_sys_in)
    s_q.ack && ana.chan == ADP_CH_MOTOR);
endmodule : adp_ana_sample

// ===== rtl/adp_aux_port.sv
/*
  Accessory-port digital outputs with preset and analog read, behind an
  Avalon-MM slave with waitrequest. Assumes a master that holds its
  request until waitrequest is low, and a trigger unit on the same clock.
*/
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
module adp_aux_port
  import adp_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic srst_in,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Trigger unit, same clock.
  input wire logic [3:0] trig_own_in,
  input wire logic [3:0] trig_level_in,
  // Converter words.
  input wire logic [15:0] aux_adc_in,
  input wire logic [15:0] motor_volt_in,
  input wire logic [15:0] gen_adc_in,
  // Output pins.
  output logic pulse_led_output_out,
  output logic direction_output_out,
  output logic shutter_output_out,
  output logic trigger_output_out
);
  typedef enum logic [1:0] {
    ADP_IDLE = 2'b00,
    ADP_ANA = 2'b01,
    ADP_DONE = 2'b11
  } adp_state_t;

  typedef struct packed {
    adp_state_t st;
    logic [3:0] outreg;
    logic [3:0] preset;
    logic led_man;
    logic shut_sel;
    logic shut_lvl;
    logic [6:0] bright;
    logic [5:0] ana_sel;
    logic ana_req;
    logic [31:0] rdata;
    logic wait_n;
    logic [3:0] pins;
  } adp_top_t;

  adp_top_t r_q, r_d;
  adp_ana_if ana ();

  adp_ana_sample #(.BITS(ADP_ADC_BITS)) u_smp (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .aux_adc_in(aux_adc_in),
    .motor_volt_in(motor_volt_in),
    .gen_adc_in(gen_adc_in),
    .ana(ana)
  );

  assign ana.req = r_q.ana_req;
  assign ana.chan = r_q.ana_sel[4:0];
  assign ana.hires = r_q.ana_sel[5];

  // Applies a string write of len characters over old.
  function automatic logic [3:0] str_merge(input logic [3:0] old,
      input logic [31:0] wd);
    logic [3:0] res;
    logic [2:0] len;
    res = old;
    len = wd[ADP_LEN_LSB +: 3];
    for (int i = 0; i < ADP_NOUT; i++) begin
      if (3'(i) < len) begin
        res[i] = wd[i];
      end
    end
    return res;
  endfunction : str_merge

  // Applies a single-bit write, refusing bad index or level.
  function automatic logic [3:0] bit_merge(input logic [3:0] old,
      input logic [31:0] wd);
    logic [3:0] res;
    logic [3:0] idx;
    logic [1:0] lvl;
    res = old;
    idx = wd[ADP_IDX_LSB +: 4];
    lvl = wd[1:0];
    if (idx < 4'(ADP_NOUT) && lvl < 2'h2) begin
      res[idx[1:0]] = lvl[0];
    end
    return res;
  endfunction : bit_merge

  logic wr_go;
  logic rd_go;
  logic [3:0] pins_d;

  always_comb begin
    r_d = r_q;
    r_d.ana_req = 1'b0;
    r_d.wait_n = 1'b0;
    wr_go = avs_write_in && r_q.st == ADP_IDLE;
    rd_go = avs_read_in && r_q.st == ADP_IDLE;
    case (r_q.st)
      ADP_IDLE: begin
        if (wr_go) begin
          r_d.st = ADP_DONE;
          r_d.wait_n = 1'b1;
          case (avs_address_in)
            ADP_OFS_OUT: r_d.outreg = str_merge(r_q.outreg,
                                                 avs_writedata_in);
            ADP_OFS_BIT: r_d.outreg = bit_merge(r_q.outreg,
                                                 avs_writedata_in);
            ADP_OFS_PRESET: r_d.preset = str_merge(r_q.preset,
                                                    avs_writedata_in);
            ADP_OFS_PBIT: r_d.preset = bit_merge(r_q.preset,
                                                  avs_writedata_in);
            ADP_OFS_CTRL: begin
              r_d.led_man = avs_writedata_in[ADP_CTRL_LED_MAN];
              r_d.shut_sel = avs_writedata_in[ADP_CTRL_SHUT_LSB];
              r_d.shut_lvl = avs_writedata_in[ADP_CTRL_SHUT_LSB + 1];
              r_d.bright = avs_writedata_in[ADP_CTRL_BRIGHT_LSB +: 7];
            end
            ADP_OFS_ANA_SEL: r_d.ana_sel = {avs_writedata_in[ADP_SEL_HIRES],
                                            avs_writedata_in[4:0]};
            default: r_d.wait_n = 1'b1;
          endcase
        end else if (rd_go) begin
          r_d.st = ADP_DONE;
          r_d.wait_n = 1'b1;
          case (avs_address_in)
            ADP_OFS_OUT: r_d.rdata = {28'h0000000, r_q.pins};
            ADP_OFS_BIT: r_d.rdata = {28'h0000000, r_q.outreg};
            ADP_OFS_PRESET: r_d.rdata = {28'h0000000, r_q.preset};
            ADP_OFS_PBIT: r_d.rdata = {28'h0000000, r_q.preset};
            ADP_OFS_CTRL: r_d.rdata = {9'h000, r_q.bright, 6'h00,
                                       r_q.shut_lvl, r_q.shut_sel, 5'h00,
                                       r_q.led_man, 2'h0};
            ADP_OFS_PIN: r_d.rdata = {31'h00000000,
                                      r_q.pins[r_q.ana_sel[1:0]]};
            ADP_OFS_ANA_SEL: r_d.rdata = {23'h000000, r_q.ana_sel[5],
                                          3'h0, r_q.ana_sel[4:0]};
            ADP_OFS_ANA_DATA: begin
              r_d.st = ADP_ANA;
              r_d.wait_n = 1'b0;
              r_d.ana_req = 1'b1;
            end
            default: r_d.rdata = ADP_UNMAPPED;
          endcase
        end
      end
      ADP_ANA: begin
        if (ana.ack) begin
          r_d.rdata = ana.value;
          r_d.wait_n = 1'b1;
          r_d.st = ADP_DONE;
        end
      end
      // A cycle back to idle after each answer stops a held request
      // from being taken twice.
      ADP_DONE: r_d.st = ADP_IDLE;
      default: r_d.st = ADP_IDLE;
    endcase

    pins_d = r_q.outreg;
    if (r_q.led_man) begin
      pins_d[0] = (r_q.bright == 7'h00);
    end
    if (r_q.shut_sel) begin
      pins_d[2] = r_q.shut_lvl;
    end
    // Trigger is applied last, so a claimed pin ignores every other source.
    // trigger owns pins.
    pins_d = (pins_d & ~trig_own_in) | (trig_level_in & trig_own_in);
    r_d.pins = pins_d;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      r_q <= '0;
      r_q.outreg <= ADP_PRESET_RST;
      r_q.pins <= ADP_PRESET_RST;
      r_q.preset <= ADP_PRESET_RST;
      r_q.st <= ADP_IDLE;
    end else begin
      r_q <= r_d;
    end
  end

  assign pulse_led_output_out = r_q.pins[0];
  assign direction_output_out = r_q.pins[1];
  assign shutter_output_out = r_q.pins[2];
  assign trigger_output_out = r_q.pins[3];
  assign avs_readdata_out = r_q.rdata;
  assign avs_waitrequest_out = !r_q.wait_n;

  a_bit_write: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (wr_go && avs_address_in == ADP_OFS_BIT &&
     avs_writedata_in[7:4] < 4 && avs_writedata_in[1:0] < 2) |=>
    r_q.outreg[$past(avs_writedata_in[5:4])] == $past(avs_writedata_in[0]))
    else $error("single write missed");
  a_bad_index: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (wr_go && avs_address_in == ADP_OFS_BIT &&
     (avs_writedata_in[7:4] > 3 || avs_writedata_in[1])) |=>
    $stable(r_q.outreg))
    else $error("bad write changed outputs");
  a_short_string: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (wr_go && avs_address_in == ADP_OFS_OUT &&
     avs_writedata_in[10:8] == 3'd2) |=>
    (r_q.outreg[3:2] == $past(r_q.outreg[3:2]) &&
     r_q.outreg[1:0] == $past(avs_writedata_in[1:0])))
    else $error("short string wrong");
  a_string_first: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (wr_go && avs_address_in == ADP_OFS_OUT &&
     avs_writedata_in[10:8] != 3'd0) |=>
    r_q.outreg[0] == $past(avs_writedata_in[0]))
    else $error("first char not bit 0");
  a_led_manual: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (r_q.led_man && r_q.bright == 7'h00 && !trig_own_in[0]) |=>
    pulse_led_output_out)
    else $error("led not high at zero");
  a_led_dim: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (r_q.led_man && r_q.bright != 7'h00 && !trig_own_in[0]) |=>
    !pulse_led_output_out)
    else $error("led not low above zero");
  a_trig_owns: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    trig_own_in[3] |=> trigger_output_out == $past(trig_level_in[3]))
    else $error("trigger not owning pin");
  a_shutter_ctl: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (r_q.shut_sel && !trig_own_in[2]) |=>
    shutter_output_out == $past(r_q.shut_lvl))
    else $error("shutter control ignored");
  a_reset_preset: assert property (@(posedge clk_sys_in)
    srst_in |=> r_q.pins == ADP_PRESET_RST)
    else $error("preset not applied");
  a_preset_bit: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (wr_go && avs_address_in == ADP_OFS_PBIT &&
     avs_writedata_in[7:4] < 4 && avs_writedata_in[1:0] < 2) |=>
    r_q.preset[$past(avs_writedata_in[5:4])] == $past(avs_writedata_in[0]))
    else $error("preset write missed");
  a_read_all: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (rd_go && avs_address_in == ADP_OFS_OUT) |=> !avs_waitrequest_out &&
    avs_readdata_out[3:0] == $past(r_q.pins))
    else $error("read of outputs wrong");
  a_read_preset: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (rd_go && avs_address_in == ADP_OFS_PRESET) |=>
    avs_readdata_out[3:0] == $past(r_q.preset))
    else $error("preset read wrong");
  a_motor_direct: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (r_q.st == ADP_ANA && ana.ack && ana.chan == ADP_CH_MOTOR) |=>
    avs_readdata_out == {16'h0000, $past(motor_volt_in, 2)})
    else $error("motor voltage not direct");
  a_ana_answer: assert property (@(posedge clk_sys_in)
    disable iff (srst_in)
    (rd_go && avs_address_in == ADP_OFS_ANA_DATA) |->
    ##[1:8] !avs_waitrequest_out)
    else $error("analog read hung");

  // Main scenarios for coverage.
  cv_string: cover property (@(posedge clk_sys_in)
    wr_go && avs_address_in == ADP_OFS_OUT);
  cv_bit: cover property (@(posedge clk_sys_in)
    wr_go && avs_address_in == ADP_OFS_BIT);
  cv_ana: cover property (@(posedge clk_sys_in)
    r_q.st == ADP_ANA && ana.ack);
endmodule : adp_aux_port

// ===== verif/adp_tb_src.sv
/*
  Far-side model: converter words and the trigger unit that faces the
  accessory port. Assumes the bench sets claim_in by non-blocking
  assignment at a rising clock edge.
*/
`timescale 1ns/1ps
module adp_tb_src
  import adp_pkg::*;
#(
  parameter logic [15:0] AUX_WORD = 16'h0ABD,
  parameter logic [15:0] MOTOR_WORD = 16'h1234,
  parameter logic [15:0] GEN_WORD = 16'h0400
) (
  // Trigger claim request from the bench.
  input wire logic claim_in,
  // Converter words.
  output logic [15:0] aux_adc_out,
  output logic [15:0] motor_volt_out,
  output logic [15:0] gen_adc_out,
  // Trigger unit.
  output logic [3:0] trig_own_out,
  output logic [3:0] trig_level_out
);
  // Words are held steady so that one sample decides the expected value.
  assign aux_adc_out = AUX_WORD;
  assign motor_volt_out = MOTOR_WORD;
  assign gen_adc_out = GEN_WORD;
  assign trig_own_out = claim_in ? 4'h8 : 4'h0;
  assign trig_level_out = claim_in ? 4'h8 : 4'h5;
endmodule : adp_tb_src

// ===== verif/tb_adp_aux_port.sv
/*
  Self-checking bench of the accessory-port block over Avalon-MM.
  Assumes the far-side model adp_tb_src and one 25 MHz clock.
*/
`timescale 1ns/1ps
module tb_adp_aux_port;
  import adp_pkg::*;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wait_req;
  logic claim = 1'b0;
  logic [15:0] aux_w, mot_w, gen_w;
  logic [3:0] own, lvl;
  logic p0, p1, p2, p3;
  logic [3:0] pins;
  logic [31:0] q;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] ana_sel [4] = '{32'h0000_000A, 32'h0000_010A,
                               32'h0000_001C, 32'h0000_0003};
  logic [31:0] ana_exp [4] = '{32'h0000_02AF, 32'h0001_5799,
                               32'h0000_1234, 32'h0000_0100};

  assign pins = {p3, p2, p1, p0};

  initial begin
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  adp_tb_src i_src (.claim_in(claim), .aux_adc_out(aux_w),
    .motor_volt_out(mot_w), .gen_adc_out(gen_w),
    .trig_own_out(own), .trig_level_out(lvl));

  adp_aux_port i_dut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wait_req), .trig_own_in(own),
    .trig_level_in(lvl), .aux_adc_in(aux_w), .motor_volt_in(mot_w),
    .gen_adc_in(gen_w), .pulse_led_output_out(p0),
    .direction_output_out(p1), .shutter_output_out(p2),
    .trigger_output_out(p3));

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // One bus cycle; the request is held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    adr <= a;
    rd <= ~w;
    wr <= w;
    wdat <= d;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wait_req !== 1'b0 && n < 100);
    r = rdat;
    if (n >= 100) begin
      $display("[FAIL] %0t bus answer missing", $time);
      bad_count++;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask : bus

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wreg

  // Pins are compared at the falling edge, where they have settled.
  task automatic chk_pins(input logic [3:0] exp);
    @(negedge clk_sys_in);
    chk({28'h0, pins}, {28'h0, exp});
    @(posedge clk_sys_in);
  endtask : chk_pins

  task automatic rreg(input logic [7:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0000_0000, r);
  endtask : rreg

  initial begin
    #(40 * 4000);
    $display("[FAIL] %0t watchdog expired", $time);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (10) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    chk_pins(ADP_PRESET_RST);
    wreg(ADP_OFS_OUT, 32'h0000_040D);
    chk_pins(4'hD);
    wreg(ADP_OFS_OUT, 32'h0000_0202);
    chk_pins(4'hE);
    wreg(ADP_OFS_BIT, 32'h0000_0030);
    chk_pins(4'h6);
    wreg(ADP_OFS_BIT, 32'h0000_0041);
    wreg(ADP_OFS_BIT, 32'h0000_0002);
    chk_pins(4'h6);
    rreg(ADP_OFS_OUT, q);
    chk({28'h0, q[3:0]}, 32'h0000_0006);
    rreg(ADP_OFS_BIT, q);
    chk({28'h0, q[3:0]}, 32'h0000_0006);
    wreg(ADP_OFS_ANA_SEL, 32'h0000_0002);
    rreg(ADP_OFS_PIN, q);
    chk({31'h0, q[0]}, 32'h0000_0001);
    wreg(ADP_OFS_ANA_SEL, 32'h0000_0000);
    rreg(ADP_OFS_PIN, q);
    chk({31'h0, q[0]}, 32'h0000_0000);
    wreg(ADP_OFS_CTRL, 32'h0000_0004);
    chk_pins(4'h7);
    wreg(ADP_OFS_CTRL, 32'h0032_0004);
    chk_pins(4'h6);
    rreg(ADP_OFS_CTRL, q);
    chk(q, 32'h0032_0004);
    wreg(ADP_OFS_CTRL, 32'h0000_0100);
    chk_pins(4'h2);
    wreg(ADP_OFS_CTRL, 32'h0000_0300);
    chk_pins(4'h6);
    wreg(ADP_OFS_CTRL, 32'h0000_0000);
    claim <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk_pins(4'hE);
    claim <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    chk_pins(4'h6);
    // Selector table covers channel 10, high resolution, 28 and other.
    for (int i = 0; i < 4; i++) begin
      wreg(ADP_OFS_ANA_SEL, ana_sel[i]);
      rreg(ADP_OFS_ANA_SEL, q);
      chk(q, ana_sel[i]);
      rreg(ADP_OFS_ANA_DATA, q);
      chk(q, ana_exp[i]);
    end
    wreg(ADP_OFS_PRESET, 32'h0000_040A);
    rreg(ADP_OFS_PRESET, q);
    chk({28'h0, q[3:0]}, 32'h0000_000A);
    wreg(ADP_OFS_PBIT, 32'h0000_0001);
    rreg(ADP_OFS_PBIT, q);
    chk({28'h0, q[3:0]}, 32'h0000_000B);
    wreg(8'h40, 32'h0000_040F);
    rreg(8'h40, q);
    chk(q, ADP_UNMAPPED);
    chk_pins(4'h6);
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    chk_pins(ADP_PRESET_RST);
    rreg(ADP_OFS_PRESET, q);
    chk(q, {28'h0, ADP_PRESET_RST});
    summarize();
  end
endmodule : tb_adp_aux_port
